// [tape_pkg.sv]
// Shared constants, types and register map for the tape transport search control.
// Assumes a single 50 MHz clock and an APB master with 32-bit data.
package tape_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_HZ = 50_000_000;
	localparam int GAP_S = 5;
	localparam int GAP_CYCLES = GAP_S * CLK_HZ;
	localparam int SETTLE_CYCLES = 4;

	// ****************************************
	// Pin inputs
	// ****************************************
	localparam int PIN_W = 10;
	localparam int B_PLAY = 0;
	localparam int B_STOP = 1;
	localparam int B_PAUSE = 2;
	localparam int B_REC = 3;
	localparam int B_REW = 4;
	localparam int B_FF = 5;
	localparam int B_CRST = 6;
	localparam int S_MEMORY = 7;
	localparam int S_TMR_PLAY = 8;
	localparam int S_TMR_REC = 9;

	// ****************************************
	// Counts
	// ****************************************
	localparam logic [9:0] TAPE_ZERO = 10'h000;
	localparam logic [9:0] TAPE_LAST = 10'h3E7;
	localparam logic [4:0] SEARCH_MIN = 5'h01;
	localparam logic [4:0] SEARCH_MAX = 5'h12;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [11:0] CONTROL_ADDR = 12'h000;
	localparam logic [11:0] STATUS_ADDR = 12'h004;
	localparam logic [7:0] THRESH_RESET = 8'h10;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_DIR_BIT = 3;
	localparam int ST_COUNT_LSB = 4;
	localparam int ST_SEARCH_BIT = 12;
	localparam int ST_TAPE_LSB = 16;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [2:0] {
		ST_STOP = 3'b000,
		ST_PLAY = 3'b001,
		ST_REC = 3'b010,
		ST_WIND = 3'b011,
		ST_CUE = 3'b100,
		ST_SEARCH = 3'b101
	} mode_e;

	typedef enum logic [2:0] {
		SPD_OFF = 3'b000,
		SPD_PLAY = 3'b001,
		SPD_FAST = 3'b010,
		SPD_THIRD = 3'b011,
		SPD_FIFTH = 3'b100
	} speed_e;

	typedef enum logic [1:0] {
		HEAD_RETRACT = 2'b00,
		HEAD_NEAR = 2'b01,
		HEAD_PLAY = 2'b10
	} head_e;

	typedef struct packed {
		logic forward;
		speed_e speed;
		head_e head;
		logic mute;
		logic record;
	} drive_s;

endpackage

// [tape_transport_search_control.sv]
// Transport control: counter memory stop, timer self-start, cueing and music search.
// Buttons and switches arrive as raw pins; audio level comes from an ADC on this clock.
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/100ps

// Function
// - Counter reset button sets the tape counter to 000 anywhere, any mode.
// - Memory switch plus rewind stops the transport when counter reaches 999.
// - Power-up with timer switch at play or record starts that mode unprompted.
// - Plain rewind or fast-forward retracts the head and mutes the output.
// - Pause during fast wind enters cue: head near tape, one-third speed.
// - In cue, holding rewind or fast-forward drops speed to about one-fifth.
// - Cue mode lasts until stop, play or a second pause is pressed.
// - Second pause during cue enters music search with count one shown.
// - Each pause in search adds one, capped at eighteen, extra presses ignored.
// - Each record press in search lowers the count by one, not below one until a selection start has passed.
// - Count N passes N-1 selection starts and stops at the Nth.
// - Searching winds tape and counts down at each detected selection start.
// - Count reaching zero at a selection start switches into playback.
// - Search follows entry direction; rewind or fast-forward reverses it mid-search.
// - Stop or play ends music search at any time.
// - Display shows selections left, one clock behind the working count that search uses.
// - A silent gap of about five seconds marks a selection boundary.
// - Search entry and counting use only the ordinary transport button inputs.
module tape_transport_search_control #(
	parameter int GAP_CYCLES = tape_pkg::GAP_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Front panel, remote and switch pins
	input wire logic [tape_pkg::PIN_W-1:0] pins,
	// Tape counter roller pulse pin
	input wire logic tape_tick,
	// Playback level from ADC on this clock
	input wire logic [7:0] level,
	// Transport and display
	output tape_pkg::drive_s drive,
	output logic [4:0] count_display,
	output logic search_indicator,
	output logic [9:0] tape_count
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [tape_pkg::PIN_W:0] sync1_r;
	logic [tape_pkg::PIN_W:0] sync2_r;
	logic [tape_pkg::PIN_W:0] sync3_r;
	logic [tape_pkg::PIN_W:0] filt_r;
	logic [tape_pkg::PIN_W:0] filt_d_r;
	logic [tape_pkg::PIN_W:0] press;

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			filt_d_r <= '0;
		end else begin
			sync1_r <= {tape_tick, pins};
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			filt_d_r <= filt_r;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi <= tape_pkg::PIN_W; gi++) begin : g_filt
			// Bounce between the last two stages is not taken as a change
			always_ff @(posedge clock) begin
				if (!reset_n) begin
					filt_r[gi] <= 1'b0;
				end else if (sync2_r[gi] == sync3_r[gi]) begin
					filt_r[gi] <= sync2_r[gi];
				end
			end
		end
	endgenerate

	assign press = filt_r & ~filt_d_r;

	// Remote and panel share these inputs
	logic p_play;
	logic p_stop;
	logic p_pause;
	logic p_rec;
	logic p_wind;
	logic p_ff;
	logic tick;
	assign p_play = press[tape_pkg::B_PLAY];
	assign p_stop = press[tape_pkg::B_STOP];
	assign p_pause = press[tape_pkg::B_PAUSE];
	assign p_rec = press[tape_pkg::B_REC];
	assign p_ff = press[tape_pkg::B_FF];
	assign p_wind = press[tape_pkg::B_FF] | press[tape_pkg::B_REW];
	assign tick = press[tape_pkg::PIN_W];

	// ****************************************
	// Registers over APB
	// ****************************************
	logic [7:0] thresh_r;
	logic [31:0] status_word;
	logic hit_ctrl;
	logic hit_stat;
	tape_pkg::mode_e mode_r;
	logic dir_r;
	logic [4:0] count_r;
	logic [9:0] tape_r;

	assign hit_ctrl = (paddr == tape_pkg::CONTROL_ADDR);
	assign hit_stat = (paddr == tape_pkg::STATUS_ADDR);
	assign pready = 1'b1;

	always_comb begin
		status_word = '0;
		status_word[tape_pkg::ST_STATE_LSB +: 3] = mode_r;
		status_word[tape_pkg::ST_DIR_BIT] = dir_r;
		status_word[tape_pkg::ST_COUNT_LSB +: 5] = count_r;
		status_word[tape_pkg::ST_SEARCH_BIT] = (mode_r == tape_pkg::ST_SEARCH);
		status_word[tape_pkg::ST_TAPE_LSB +: 10] = tape_r;
	end

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			thresh_r <= tape_pkg::THRESH_RESET;
		end else if (psel && penable && pwrite && hit_ctrl) begin
			thresh_r <= pwdata[7:0];
		end
	end

	// Read data latched in the setup cycle, so it stands from a flop
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			prdata <= '0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pslverr <= !(hit_ctrl || hit_stat);
			if (pwrite) begin
				prdata <= '0;
			end else if (hit_ctrl) begin
				prdata <= {24'h000000, thresh_r};
			end else if (hit_stat) begin
				prdata <= status_word;
			end else begin
				prdata <= '0;
			end
		end
	end

	// ****************************************
	// Self-start catch after reset release
	// ****************************************
	logic [2:0] settle_r;
	logic boot;
	assign boot = (settle_r == 3'(tape_pkg::SETTLE_CYCLES));

	// One pulse, only once the filter stage holds the timer switch
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			settle_r <= '0;
		end else if (settle_r != 3'(tape_pkg::SETTLE_CYCLES + 1)) begin
			settle_r <= settle_r + 3'h1;
		end
	end

	// ****************************************
	// Silence detector
	// ****************************************
	logic [31:0] quiet_r;
	logic gap_seen_r;
	logic sel_start;
	logic quiet;
	assign quiet = (level < thresh_r);
	// Edge of sound after a long gap is the start of a selection
	assign sel_start = gap_seen_r && !quiet && (mode_r == tape_pkg::ST_SEARCH);

	// Gap timed in clock time at cue speed; quiet passages also count
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			quiet_r <= '0;
			gap_seen_r <= 1'b0;
		end else if (mode_r != tape_pkg::ST_SEARCH) begin
			quiet_r <= '0;
			gap_seen_r <= 1'b0;
		end else if (quiet) begin
			if (quiet_r >= 32'(GAP_CYCLES - 1)) begin
				gap_seen_r <= 1'b1;
			end else begin
				quiet_r <= quiet_r + 32'h1;
			end
		end else begin
			quiet_r <= '0;
			gap_seen_r <= 1'b0;
		end
	end

	// ****************************************
	// Search count
	// ****************************************
	logic started_r;
	logic land;
	// Landing when the last selection start is passed
	assign land = sel_start && (count_r == tape_pkg::SEARCH_MIN);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			count_r <= '0;
			started_r <= 1'b0;
		end else if (mode_r == tape_pkg::ST_CUE && p_pause) begin
			count_r <= tape_pkg::SEARCH_MIN;
			started_r <= 1'b0;
		end else if (mode_r == tape_pkg::ST_SEARCH && !p_stop && !p_play) begin
			if (sel_start) begin
				count_r <= count_r - 5'h01;
				started_r <= 1'b1;
			end else if (p_pause) begin
				if (count_r < tape_pkg::SEARCH_MAX) begin
					count_r <= count_r + 5'h01;
				end
			end else if (p_rec) begin
				if (count_r > tape_pkg::SEARCH_MIN || (started_r && count_r != 5'h00)) begin
					count_r <= count_r - 5'h01;
				end
			end
		end else if (mode_r != tape_pkg::ST_SEARCH) begin
			count_r <= '0;
			started_r <= 1'b0;
		end
	end

	// ****************************************
	// Transport mode
	// ****************************************
	logic mem_stop;
	// Counter wraps 000 to 999 going backward
	assign mem_stop = filt_r[tape_pkg::S_MEMORY] && !dir_r && (tape_r == tape_pkg::TAPE_LAST);

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mode_r <= tape_pkg::ST_STOP;
			dir_r <= 1'b1;
		end else if (boot) begin
			if (filt_r[tape_pkg::S_TMR_REC]) begin
				mode_r <= tape_pkg::ST_REC;
			end else if (filt_r[tape_pkg::S_TMR_PLAY]) begin
				mode_r <= tape_pkg::ST_PLAY;
			end
			dir_r <= 1'b1;
		end else begin
			case (mode_r)
				tape_pkg::ST_STOP, tape_pkg::ST_PLAY, tape_pkg::ST_REC: begin
					if (p_stop) begin
						mode_r <= tape_pkg::ST_STOP;
					end else if (p_wind) begin
						mode_r <= tape_pkg::ST_WIND;
						dir_r <= p_ff;
					end else if (p_play && mode_r == tape_pkg::ST_STOP) begin
						if (filt_r[tape_pkg::B_REC]) begin
							mode_r <= tape_pkg::ST_REC;
						end else begin
							mode_r <= tape_pkg::ST_PLAY;
						end
						dir_r <= 1'b1;
					end
				end
				tape_pkg::ST_WIND: begin
					if (p_stop || mem_stop) begin
						mode_r <= tape_pkg::ST_STOP;
					end else if (p_play) begin
						mode_r <= tape_pkg::ST_PLAY;
						dir_r <= 1'b1;
					end else if (p_pause) begin
						mode_r <= tape_pkg::ST_CUE;
					end else if (p_wind) begin
						dir_r <= p_ff;
					end
				end
				tape_pkg::ST_CUE: begin
					if (p_stop) begin
						mode_r <= tape_pkg::ST_STOP;
					end else if (p_play) begin
						mode_r <= tape_pkg::ST_PLAY;
						dir_r <= 1'b1;
					end else if (p_pause) begin
						mode_r <= tape_pkg::ST_SEARCH;
					end
				end
				tape_pkg::ST_SEARCH: begin
					if (p_stop) begin
						mode_r <= tape_pkg::ST_STOP;
					end else if (p_play || land) begin
						mode_r <= tape_pkg::ST_PLAY;
						dir_r <= 1'b1;
					end else if (p_wind) begin
						dir_r <= !dir_r;
					end
				end
				default: begin
					mode_r <= tape_pkg::ST_STOP;
				end
			endcase
		end
	end

	// ****************************************
	// Tape counter
	// ****************************************
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			tape_r <= tape_pkg::TAPE_ZERO;
		end else if (press[tape_pkg::B_CRST]) begin
			tape_r <= tape_pkg::TAPE_ZERO;
		end else if (tick && mode_r != tape_pkg::ST_STOP) begin
			if (dir_r) begin
				tape_r <= (tape_r == tape_pkg::TAPE_LAST) ? tape_pkg::TAPE_ZERO : tape_r + 10'h001;
			end else begin
				tape_r <= (tape_r == tape_pkg::TAPE_ZERO) ? tape_pkg::TAPE_LAST : tape_r - 10'h001;
			end
		end
	end

	// ****************************************
	// Motor, head and mute drive
	// ****************************************
	logic held;
	assign held = filt_r[tape_pkg::B_FF] | filt_r[tape_pkg::B_REW];

	always_ff @(posedge clock) begin
		if (!reset_n) begin
			drive <= '{forward: 1'b1, speed: tape_pkg::SPD_OFF, head: tape_pkg::HEAD_RETRACT, mute: 1'b1,
				record: 1'b0};
		end else begin
			drive.forward <= dir_r;
			drive.record <= (mode_r == tape_pkg::ST_REC);
			case (mode_r)
				tape_pkg::ST_PLAY, tape_pkg::ST_REC: begin
					drive.speed <= tape_pkg::SPD_PLAY;
					drive.head <= tape_pkg::HEAD_PLAY;
					drive.mute <= 1'b0;
				end
				tape_pkg::ST_WIND: begin
					drive.speed <= tape_pkg::SPD_FAST;
					drive.head <= tape_pkg::HEAD_RETRACT;
					drive.mute <= 1'b1;
				end
				tape_pkg::ST_CUE: begin
					// Held wind button slows cue further
					drive.speed <= held ? tape_pkg::SPD_FIFTH : tape_pkg::SPD_THIRD;
					drive.head <= tape_pkg::HEAD_NEAR;
					drive.mute <= 1'b0;
				end
				tape_pkg::ST_SEARCH: begin
					// Head near so the level input sees the tape
					drive.speed <= tape_pkg::SPD_THIRD;
					drive.head <= tape_pkg::HEAD_NEAR;
					drive.mute <= 1'b1;
				end
				default: begin
					drive.speed <= tape_pkg::SPD_OFF;
					drive.head <= tape_pkg::HEAD_RETRACT;
					drive.mute <= 1'b1;
				end
			endcase
		end
	end

	// ****************************************
	// Display
	// ****************************************
	// Display is a registered copy of the working count, one clock behind
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			count_display <= '0;
			search_indicator <= 1'b0;
			tape_count <= tape_pkg::TAPE_ZERO;
		end else begin
			count_display <= count_r;
			search_indicator <= (mode_r == tape_pkg::ST_SEARCH);
			tape_count <= tape_r;
		end
	end

endmodule

// [search_checker.sv]
// Port-level checks for the transport search control.
// Assumes a bind onto the top module, one clock, synchronous active-low reset.
`timescale 1ns/100ps
module search_checker #(
	parameter int GAP_CYCLES = 20
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Pins and outputs
	input wire logic [tape_pkg::PIN_W-1:0] pins,
	input wire tape_pkg::drive_s drive,
	input wire logic [4:0] count_display,
	input wire logic search_indicator,
	input wire logic [9:0] tape_count
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	// ****************************************
	// Assertions
	// ****************************************
	a_count_cap: assert property (count_display <= tape_pkg::SEARCH_MAX)
		else $error("search count above ceiling");
	a_wind_quiet: assert property (drive.speed == tape_pkg::SPD_FAST |->
		drive.head == tape_pkg::HEAD_RETRACT && drive.mute) else $error("fast wind not muted");
	a_cue_near: assert property (drive.speed inside {tape_pkg::SPD_THIRD, tape_pkg::SPD_FIFTH} |->
		drive.head == tape_pkg::HEAD_NEAR) else $error("slow wind without head near");
	a_search_one: assert property ($rose(search_indicator) |-> count_display == tape_pkg::SEARCH_MIN)
		else $error("search entry count not one");
	a_count_step: assert property (search_indicator && $past(search_indicator) |->
		(count_display - $past(count_display)) inside {5'h00, 5'h01, 5'h1F}) else $error("count jumped");
	a_tape_range: assert property (tape_count <= tape_pkg::TAPE_LAST)
		else $error("tape count out of range");
	a_counter_clear: assert property ($rose(pins[tape_pkg::B_CRST]) |->
		##[3:10] tape_count == tape_pkg::TAPE_ZERO) else $error("counter not cleared");
	a_memory_stop: assert property (pins[tape_pkg::S_MEMORY] && !drive.forward &&
		drive.speed == tape_pkg::SPD_FAST && tape_count == tape_pkg::TAPE_LAST |->
		##[1:6] drive.speed == tape_pkg::SPD_OFF) else $error("memory stop missed");

	// ****************************************
	// Covers
	// ****************************************
	c_search: cover property ($rose(search_indicator));
	c_fifth: cover property (drive.speed == tape_pkg::SPD_FIFTH);
	c_full: cover property (count_display == tape_pkg::SEARCH_MAX);
endmodule

bind tape_transport_search_control search_checker #(.GAP_CYCLES(GAP_CYCLES)) chk (.clock(clock),
	.reset_n(reset_n), .pins(pins), .drive(drive), .count_display(count_display),
	.search_indicator(search_indicator), .tape_count(tape_count));

// [tape_mech.sv]
// Behavioural tape mechanism: counter roller pulses and playback level.
// Assumes the bench raises quiet to lay a silent gap on the tape.
`timescale 1ns/100ps
module tape_mech (
	// Clock and transport
	input wire logic clock,
	input wire tape_pkg::drive_s drive,
	input wire logic quiet,
	// Roller and audio
	output logic tape_tick,
	output logic [7:0] level
);
	logic [1:0] phase_r = 2'h0;
	initial tape_tick = 1'h0;
	// Roller only turns while a motor runs
	// Two cycles high, since a one-cycle pulse never shows in both filter stages at once
	always @(posedge clock) begin
		phase_r <= phase_r + 2'h1;
		tape_tick <= drive.speed != tape_pkg::SPD_OFF && !phase_r[1];
	end
	// Music wobbles so a stuck level is not mistaken for sound
	assign level = quiet ? 8'h02 : {7'h40, phase_r[0]};
endmodule

// [test_tape_transport_search_control.sv]
// Self-checking bench for the transport search control.
// Assumes a short gap parameter; presses are held long enough for the pin filter.
`timescale 1ns/100ps
module test_tape_transport_search_control;
	localparam int GAP = 20;
	logic clock = 1'h0;
	logic reset_n = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [tape_pkg::PIN_W-1:0] pins = '0;
	logic quiet = 1'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic tape_tick;
	logic [7:0] level;
	tape_pkg::drive_s drive;
	logic [4:0] count_display;
	logic search_indicator;
	logic [9:0] tape_count;
	logic [31:0] rd;
	logic er;
	int n_fail = 0;
	int samples_checked = 0;

	tape_transport_search_control #(.GAP_CYCLES(GAP)) dut (.clock(clock), .reset_n(reset_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins(pins), .tape_tick(tape_tick), .level(level), .drive(drive),
		.count_display(count_display), .search_indicator(search_indicator), .tape_count(tape_count));
	tape_mech mech (.clock(clock), .drive(drive), .quiet(quiet), .tape_tick(tape_tick), .level(level));

	initial begin
		forever #10 clock = ~clock;
	end

	// ****************************************
	// Tasks
	// ****************************************
	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %0t saw %0h want %0h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("checked %0d mismatched %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
		int i;
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		i = 0;
		do begin
			@(posedge clock);
			i++;
		end while (pready !== 1'h1 && i < 40);
		if (i >= 40) begin
			n_fail++;
			give_verdict;
		end
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask

	// Held past sync and filter, then released just as long
	task press(input int b);
		pins[b] <= 1'h1;
		repeat (8) @(posedge clock);
		pins[b] <= 1'h0;
		repeat (8) @(posedge clock);
	endtask

	task gap;
		quiet <= 1'h1;
		repeat (GAP + 4) @(posedge clock);
		quiet <= 1'h0;
		repeat (12) @(posedge clock);
	endtask

	task endt(input string s);
		$display("test %s done", s);
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		n_fail++;
		give_verdict;
	end

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge clock);
		reset_n <= 1'h1;
		repeat (8) @(posedge clock);
		apb(1'h0, tape_pkg::CONTROL_ADDR, 32'h0, rd, er);
		check(rd, {24'h0, tape_pkg::THRESH_RESET});
		check(er, 1'h0);
		apb(1'h1, tape_pkg::CONTROL_ADDR, 32'h20, rd, er);
		apb(1'h0, tape_pkg::CONTROL_ADDR, 32'h0, rd, er);
		check(rd, 32'h20);
		apb(1'h0, 12'h008, 32'h0, rd, er);
		check(rd, 32'h0);
		check(er, 1'h1);
		endt("registers");
		press(tape_pkg::B_FF);
		check({drive.speed, drive.head, drive.mute}, {tape_pkg::SPD_FAST, tape_pkg::HEAD_RETRACT, 1'h1});
		press(tape_pkg::B_PAUSE);
		check({drive.speed, drive.head}, {tape_pkg::SPD_THIRD, tape_pkg::HEAD_NEAR});
		pins[tape_pkg::B_FF] <= 1'h1;
		repeat (10) @(posedge clock);
		check(drive.speed, tape_pkg::SPD_FIFTH);
		pins[tape_pkg::B_FF] <= 1'h0;
		repeat (10) @(posedge clock);
		press(tape_pkg::B_PAUSE);
		check({search_indicator, count_display}, {1'h1, 5'h01});
		repeat (18) press(tape_pkg::B_PAUSE);
		check(count_display, tape_pkg::SEARCH_MAX);
		repeat (16) press(tape_pkg::B_REC);
		check(count_display, 5'h02);
		press(tape_pkg::B_REW);
		check(drive.forward, 1'h0);
		press(tape_pkg::B_FF);
		check(drive.forward, 1'h1);
		gap;
		check(count_display, 5'h01);
		gap;
		check({count_display, drive.speed}, {5'h00, tape_pkg::SPD_PLAY});
		apb(1'h0, tape_pkg::STATUS_ADDR, 32'h0, rd, er);
		check(rd[2:0], tape_pkg::ST_PLAY);
		endt("search");
		press(tape_pkg::B_STOP);
		press(tape_pkg::B_CRST);
		check(tape_count, tape_pkg::TAPE_ZERO);
		pins[tape_pkg::S_MEMORY] <= 1'h1;
		press(tape_pkg::B_REW);
		repeat (20) @(posedge clock);
		check({tape_count, drive.speed}, {tape_pkg::TAPE_LAST, tape_pkg::SPD_OFF});
		pins[tape_pkg::S_MEMORY] <= 1'h0;
		endt("memory");
		press(tape_pkg::B_FF);
		press(tape_pkg::B_PAUSE);
		press(tape_pkg::B_PLAY);
		check(drive.speed, tape_pkg::SPD_PLAY);
		press(tape_pkg::B_STOP);
		press(tape_pkg::B_REW);
		press(tape_pkg::B_PAUSE);
		press(tape_pkg::B_PAUSE);
		press(tape_pkg::B_REC);
		check({count_display, drive.forward}, {5'h01, 1'h0});
		press(tape_pkg::B_STOP);
		check({search_indicator, drive.speed}, {1'h0, tape_pkg::SPD_OFF});
		endt("exit");
		pins[tape_pkg::S_TMR_REC] <= 1'h1;
		reset_n <= 1'h0;
		repeat (8) @(posedge clock);
		reset_n <= 1'h1;
		repeat (12) @(posedge clock);
		check({drive.speed, drive.record}, {tape_pkg::SPD_PLAY, 1'h1});
		press(tape_pkg::B_STOP);
		check(drive.speed, tape_pkg::SPD_OFF);
		pins[tape_pkg::S_TMR_REC] <= 1'h0;
		endt("timer");
		give_verdict;
	end
endmodule
